// *** inc/siqr_pkg.sv ***
// Function
// - A configuration-capacity query is answered by one configuration-capacity report.
// - The configuration-capacity report goes out only as that answer, never unsolicited.
// - Reported configuration maximum is a decimal value from 1 to 99.
// - Reported configuration stored count lies from 0 up to the reported maximum.
// - A configuration-name query opens a name session carrying stored configuration names.
// - The session opening message carries a record count from 0 to 99.
// - After opening, send the name records, then a session closing message.
// - Name records are sent only while a name session is open.
// - Each name record carries exactly one name of 1 to 16 characters.
// - The closing message ends the session; no records of it follow.
// - A session error carries a four-character cause; NREC means wrong record count.
// - A FIG-file-capacity query is answered by one FIG-file-capacity report.
// - The FIG-file-capacity report goes out only as that answer.
// - Reported FIG file maximum is a decimal value from 1 to 99.
// - Reported FIG file stored count lies from 0 up to the reported maximum.
package siqr_pkg;

	// Register byte offsets
	localparam logic [7:0] SIQR_CTRL_OFS = 8'h00;
	localparam logic [7:0] SIQR_CFG_CNT_OFS = 8'h04;
	localparam logic [7:0] SIQR_FIG_CNT_OFS = 8'h08;
	localparam logic [7:0] SIQR_NAME_SEL_OFS = 8'h0C;
	localparam logic [7:0] SIQR_NAME_W0_OFS = 8'h10;
	localparam logic [7:0] SIQR_NAME_W3_OFS = 8'h1C;
	localparam logic [7:0] SIQR_STATUS_OFS = 8'h20;
	localparam logic [7:0] SIQR_IRQ_STAT_OFS = 8'h24;
	localparam logic [7:0] SIQR_IRQ_CLR_OFS = 8'h28;
	localparam logic [7:0] SIQR_IRQ_EN_OFS = 8'h2C;

	// Field positions
	localparam int SIQR_MAX_LSB = 0;
	localparam int SIQR_USED_LSB = 8;
	localparam int SIQR_LEN_LSB = 16;
	localparam int SIQR_CTRL_EN_BIT = 0;

	// Reset values
	localparam logic [31:0] SIQR_CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] SIQR_CNT_RST = 32'h0000_0001;

	// Decimal field limits
	localparam logic [6:0] SIQR_MAX_LO = 7'h01;
	localparam logic [6:0] SIQR_MAX_HI = 7'h63;
	localparam logic [4:0] SIQR_NAME_LEN_MAX = 5'h10;
	localparam int SIQR_NAME_BITS = 128;
	localparam int SIQR_IRQ_N = 4;

	// Four-character cause of a wrong record count, ASCII "NREC"
	localparam logic [31:0] SIQR_CAUSE_RECORD_COUNT = 32'h4E52_4543;

	// Interrupt event positions
	localparam int SIQR_EV_CFG_CAP = 0;
	localparam int SIQR_EV_FIG_CAP = 1;
	localparam int SIQR_EV_SESS_END = 2;
	localparam int SIQR_EV_PEER_ERR = 3;

	// AXI responses
	localparam logic [1:0] SIQR_RESP_OKAY = 2'h0;
	localparam logic [1:0] SIQR_RESP_SLVERR = 2'h2;

	// Incoming decoded query kinds
	typedef enum logic [1:0] {
		SIQR_Q_CFG_CAP,
		SIQR_Q_CFG_NAMES,
		SIQR_Q_FIG_CAP,
		SIQR_Q_PEER_ERR
	} siqr_qkind_t;

	typedef struct packed {
		siqr_qkind_t kind;
		logic [31:0] cause;
	} siqr_query_t;

	// Outgoing message kinds
	typedef enum logic [2:0] {
		SIQR_M_NONE,
		SIQR_M_CFG_REPORT,
		SIQR_M_FIG_REPORT,
		SIQR_M_NAME_OPEN,
		SIQR_M_NAME_REC,
		SIQR_M_NAME_CLOSE
	} siqr_mkind_t;

	// Counts are binary; the link formatter renders them as decimal text
	typedef struct packed {
		siqr_mkind_t kind;
		logic [6:0] num_a;
		logic [6:0] num_b;
		logic [4:0] name_len;
		logic [127:0] name;
	} siqr_msg_t;

endpackage : siqr_pkg

// *** design/siqr_responder.sv ***
// The register offsets and the AXI4-Lite register port are this design's own decisions.
module siqr_responder import siqr_pkg::*; #(
	parameter int NAME_DEPTH = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Decoded incoming queries
	input wire siqr_query_t qry,
	input wire logic qry_valid,
	output logic qry_ready,
	// Outgoing messages
	output siqr_msg_t msg,
	output logic msg_valid,
	input wire logic msg_ready,
	// Interrupt
	output logic irq
);

	localparam int IDXW = (NAME_DEPTH > 1) ? $clog2(NAME_DEPTH) : 1;

	// Parameter check
	if (NAME_DEPTH < 1 || NAME_DEPTH > 99) begin : g_bad_depth
		$error("NAME_DEPTH must lie from 1 to 99");
	end

	typedef enum logic [2:0] {
		SIQR_IDLE,
		SIQR_CAP_TX,
		SIQR_OPEN_TX,
		SIQR_REC_TX,
		SIQR_CLOSE_TX
	} siqr_state_t;

	// Bus channel state
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_got_q, w_got_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q, rd_mux;
	logic [3:0] w_strb_q;

	// Software registers
	logic [31:0] ctrl_q, cfg_cnt_q, fig_cnt_q, name_sel_q;
	logic [SIQR_IRQ_N-1:0] irq_st_q, irq_st_d, irq_en_q, irq_ev;
	logic irq_q;

	// Name storage
	logic [SIQR_NAME_BITS-1:0] name_mem [NAME_DEPTH];
	logic [4:0] name_len_mem [NAME_DEPTH];

	// Engine state
	siqr_state_t state_q, state_d;
	siqr_msg_t msg_q, msg_d;
	logic msg_valid_q, msg_valid_d, qry_ready_q;
	logic [6:0] rec_idx_q, rec_idx_d, rec_total_q, rec_total_d;

	// Handshakes and decode
	wire aw_hs = s_axi_awvalid & awready_q;
	wire w_hs = s_axi_wvalid & wready_q;
	wire ar_hs = s_axi_arvalid & arready_q;
	wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
	wire aw_got_d = (aw_got_q | aw_hs) & ~do_wr;
	wire w_got_d = (w_got_q | w_hs) & ~do_wr;
	wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire wr_ctrl = do_wr & (aw_addr_q == SIQR_CTRL_OFS);
	wire wr_cfg = do_wr & (aw_addr_q == SIQR_CFG_CNT_OFS);
	wire wr_fig = do_wr & (aw_addr_q == SIQR_FIG_CNT_OFS);
	wire wr_sel = do_wr & (aw_addr_q == SIQR_NAME_SEL_OFS);
	wire wr_name = do_wr & (aw_addr_q >= SIQR_NAME_W0_OFS) & (aw_addr_q <= SIQR_NAME_W3_OFS);
	wire wr_clr = do_wr & (aw_addr_q == SIQR_IRQ_CLR_OFS);
	wire wr_en = do_wr & (aw_addr_q == SIQR_IRQ_EN_OFS);
	wire wr_stat = do_wr & (aw_addr_q == SIQR_STATUS_OFS || aw_addr_q == SIQR_IRQ_STAT_OFS);
	wire wr_ok = wr_ctrl | wr_cfg | wr_fig | wr_sel | wr_name | wr_clr | wr_en | wr_stat;
	wire [1:0] name_word = aw_addr_q[3:2];
	wire [IDXW-1:0] sel_idx = name_sel_q[IDXW-1:0];
	wire sel_in_range = (name_sel_q[6:0] < 7'(NAME_DEPTH));

	// Merge written bytes into a register value
	function automatic logic [31:0] siqr_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [31:0] m);
		siqr_merge = (old & ~m) | (nw & m);
	endfunction : siqr_merge

	// Clamp a maximum into 1..99 and a stored count under it
	function automatic logic [6:0] siqr_clamp_max(input logic [6:0] v);
		siqr_clamp_max = (v < SIQR_MAX_LO) ? SIQR_MAX_LO : (v > SIQR_MAX_HI) ? SIQR_MAX_HI : v;
	endfunction : siqr_clamp_max

	wire [6:0] cfg_max = siqr_clamp_max(cfg_cnt_q[SIQR_MAX_LSB +: 7]);
	wire [6:0] cfg_used = (cfg_cnt_q[SIQR_USED_LSB +: 7] > cfg_max) ? cfg_max :
		cfg_cnt_q[SIQR_USED_LSB +: 7];
	wire [6:0] fig_max = siqr_clamp_max(fig_cnt_q[SIQR_MAX_LSB +: 7]);
	wire [6:0] fig_used = (fig_cnt_q[SIQR_USED_LSB +: 7] > fig_max) ? fig_max :
		fig_cnt_q[SIQR_USED_LSB +: 7];
	// record count within 0..99 and held names
	wire [6:0] rec_count = (cfg_used > 7'(NAME_DEPTH)) ? 7'(NAME_DEPTH) : cfg_used;

	wire qry_hs = qry_valid & qry_ready_q;
	wire msg_hs = msg_valid_q & msg_ready;
	// Index of the record that follows the one just taken, kept out of the engine loop
	wire [6:0] next_idx = (state_q == SIQR_REC_TX) ? rec_idx_q + 7'h01 : rec_idx_q;
	wire [IDXW-1:0] rd_idx = next_idx[IDXW-1:0];
	wire [4:0] raw_len = name_len_mem[rd_idx];
	wire [4:0] rec_len = (raw_len == 5'h00) ? 5'h01 :
		(raw_len > SIQR_NAME_LEN_MAX) ? SIQR_NAME_LEN_MAX : raw_len;

	// Write channel handshake and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= SIQR_RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awready_q <= ~aw_got_d;
			wready_q <= ~w_got_d;
			if (aw_hs) begin
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? SIQR_RESP_OKAY : SIQR_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= SIQR_CTRL_RST;
			cfg_cnt_q <= SIQR_CNT_RST;
			fig_cnt_q <= SIQR_CNT_RST;
			name_sel_q <= 32'h0000_0000;
			irq_en_q <= '0;
		end else begin
			if (wr_ctrl) ctrl_q <= siqr_merge(ctrl_q, w_data_q, wmask);
			if (wr_cfg) cfg_cnt_q <= siqr_merge(cfg_cnt_q, w_data_q, wmask);
			if (wr_fig) fig_cnt_q <= siqr_merge(fig_cnt_q, w_data_q, wmask);
			if (wr_sel) name_sel_q <= siqr_merge(name_sel_q, w_data_q, wmask);
			if (wr_en) irq_en_q <= w_data_q[SIQR_IRQ_N-1:0];
		end
	end

	// Name storage writes, no reset on data memory
	always_ff @(posedge aclk) begin
		if (wr_name && sel_in_range) begin
			name_mem[sel_idx][{name_word, 5'h00} +: 32] <= siqr_merge(
				name_mem[sel_idx][{name_word, 5'h00} +: 32], w_data_q, wmask);
		end
		if (wr_sel && (w_data_q[6:0] < 7'(NAME_DEPTH)) && w_strb_q[2]) begin
			name_len_mem[w_data_q[IDXW-1:0]] <= w_data_q[SIQR_LEN_LSB +: 5];
		end
	end

	// Read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (s_axi_araddr)
			SIQR_CTRL_OFS: rd_mux = ctrl_q;
			SIQR_CFG_CNT_OFS: rd_mux = {16'h0000, 1'b0, cfg_used, 1'b0, cfg_max};
			SIQR_FIG_CNT_OFS: rd_mux = {16'h0000, 1'b0, fig_used, 1'b0, fig_max};
			SIQR_NAME_SEL_OFS: rd_mux = name_sel_q;
			SIQR_STATUS_OFS: rd_mux = {13'h0000, 3'(state_q), 1'b0, rec_total_q, 1'b0, rec_idx_q};
			SIQR_IRQ_STAT_OFS: rd_mux = 32'(irq_st_q);
			SIQR_IRQ_EN_OFS: rd_mux = 32'(irq_en_q);
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	wire rd_ok = (s_axi_araddr == SIQR_CTRL_OFS) | (s_axi_araddr == SIQR_CFG_CNT_OFS) |
		(s_axi_araddr == SIQR_FIG_CNT_OFS) | (s_axi_araddr == SIQR_NAME_SEL_OFS) |
		(s_axi_araddr == SIQR_STATUS_OFS) | (s_axi_araddr == SIQR_IRQ_STAT_OFS) |
		(s_axi_araddr == SIQR_IRQ_EN_OFS) | (s_axi_araddr == SIQR_IRQ_CLR_OFS) |
		((s_axi_araddr >= SIQR_NAME_W0_OFS) & (s_axi_araddr <= SIQR_NAME_W3_OFS));

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= SIQR_RESP_OKAY;
		end else if (ar_hs) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_ok ? SIQR_RESP_OKAY : SIQR_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// Message engine next state
	always_comb begin
		state_d = state_q;
		msg_d = msg_q;
		msg_valid_d = msg_valid_q;
		rec_idx_d = rec_idx_q;
		rec_total_d = rec_total_q;
		irq_ev = '0;
		unique case (state_q)
			SIQR_IDLE: begin
				if (qry_hs) begin
					unique case (qry.kind)
						SIQR_Q_CFG_CAP: begin
							msg_d = '{SIQR_M_CFG_REPORT, cfg_max, cfg_used, 5'h00, '0};
							msg_valid_d = 1'b1;
							state_d = SIQR_CAP_TX;
							irq_ev[SIQR_EV_CFG_CAP] = 1'b1;
						end
						SIQR_Q_FIG_CAP: begin
							msg_d = '{SIQR_M_FIG_REPORT, fig_max, fig_used, 5'h00, '0};
							msg_valid_d = 1'b1;
							state_d = SIQR_CAP_TX;
							irq_ev[SIQR_EV_FIG_CAP] = 1'b1;
						end
						SIQR_Q_CFG_NAMES: begin
							msg_d = '{SIQR_M_NAME_OPEN, rec_count, 7'h00, 5'h00, '0};
							msg_valid_d = 1'b1;
							rec_total_d = rec_count;
							rec_idx_d = 7'h00;
							state_d = SIQR_OPEN_TX;
						end
						SIQR_Q_PEER_ERR: begin
							irq_ev[SIQR_EV_PEER_ERR] = (qry.cause == SIQR_CAUSE_RECORD_COUNT);
						end
					endcase
				end
			end
			SIQR_CAP_TX: begin
				if (msg_hs) begin
					msg_valid_d = 1'b0;
					msg_d.kind = SIQR_M_NONE;
					state_d = SIQR_IDLE;
				end
			end
			SIQR_OPEN_TX, SIQR_REC_TX: begin
				if (msg_hs) begin
					rec_idx_d = next_idx;
					if (next_idx < rec_total_q) begin
						msg_d = '{SIQR_M_NAME_REC, next_idx, 7'h00, rec_len, name_mem[rd_idx]};
						state_d = SIQR_REC_TX;
					end else begin
						msg_d = '{SIQR_M_NAME_CLOSE, 7'h00, 7'h00, 5'h00, '0};
						state_d = SIQR_CLOSE_TX;
					end
				end
			end
			SIQR_CLOSE_TX: begin
				if (msg_hs) begin
					msg_valid_d = 1'b0;
					msg_d.kind = SIQR_M_NONE;
					state_d = SIQR_IDLE;
					irq_ev[SIQR_EV_SESS_END] = 1'b1;
				end
			end
			default: state_d = SIQR_IDLE;
		endcase
	end

	// Message engine registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= SIQR_IDLE;
			msg_q <= '0;
			msg_valid_q <= 1'b0;
			rec_idx_q <= 7'h00;
			rec_total_q <= 7'h00;
			qry_ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			msg_q <= msg_d;
			msg_valid_q <= msg_valid_d;
			rec_idx_q <= rec_idx_d;
			rec_total_q <= rec_total_d;
			qry_ready_q <= (state_d == SIQR_IDLE) & ctrl_q[SIQR_CTRL_EN_BIT];
		end
	end

	// Sticky events, a new event beats a clear in the same cycle
	assign irq_st_d = (irq_st_q & ~(wr_clr ? w_data_q[SIQR_IRQ_N-1:0] : '0)) | irq_ev;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			irq_q <= |(irq_st_d & irq_en_q);
		end
	end

	// Output drive
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign qry_ready = qry_ready_q;
	assign msg = msg_q;
	assign msg_valid = msg_valid_q;
	assign irq = irq_q;

endmodule : siqr_responder

// *** bench/siqr_responder_assertions.sv ***
module siqr_responder_assertions import siqr_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link ports
	input wire siqr_query_t qry,
	input wire logic qry_valid,
	input wire logic qry_ready,
	input wire siqr_msg_t msg,
	input wire logic msg_valid,
	input wire logic msg_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic open_q;
	logic [6:0] cnt_q;
	logic [6:0] tot_q;
	// Handshake and kind decodes
	wire logic take = msg_valid && msg_ready;
	wire logic q_take = qry_valid && qry_ready;
	wire logic ask_cfg = q_take && qry.kind == SIQR_Q_CFG_CAP;
	wire logic ask_fig = q_take && qry.kind == SIQR_Q_FIG_CAP;
	wire logic is_rec = msg_valid && msg.kind == SIQR_M_NAME_REC;
	wire logic is_end = msg_valid && msg.kind == SIQR_M_NAME_CLOSE;
	// Tracks the open session and counts its records
	always_ff @(posedge aclk) begin
		if (!aresetn || (take && is_end)) begin
			open_q <= 1'b0;
			cnt_q <= 7'h00;
			tot_q <= 7'h00;
		end else if (take && msg.kind == SIQR_M_NAME_OPEN) begin
			open_q <= 1'b1;
			tot_q <= msg.num_a;
		end else if (take && is_rec) begin
			cnt_q <= cnt_q + 7'h01;
		end
	end
	sequence s_ask(siqr_qkind_t k);
		q_take && qry.kind == k;
	endsequence
	sequence s_opened;
		take && msg.kind == SIQR_M_NAME_OPEN;
	endsequence
	chk_cfg_answer: assert property (
		s_ask(SIQR_Q_CFG_CAP) |=> msg_valid && msg.kind == SIQR_M_CFG_REPORT)
		else $error("cfg query unanswered");
	chk_cfg_unasked: assert property (
		$rose(msg_valid) && msg.kind == SIQR_M_CFG_REPORT |-> $past(ask_cfg))
		else $error("cfg report unsolicited");
	chk_fig_answer: assert property (
		s_ask(SIQR_Q_FIG_CAP) |=> msg_valid && msg.kind == SIQR_M_FIG_REPORT)
		else $error("fig query unanswered");
	chk_fig_unasked: assert property (
		$rose(msg_valid) && msg.kind == SIQR_M_FIG_REPORT |-> $past(ask_fig))
		else $error("fig report unsolicited");
	chk_cap_range: assert property (
		msg_valid && msg.kind inside {SIQR_M_CFG_REPORT, SIQR_M_FIG_REPORT}
		|-> msg.num_a inside {[7'h01:7'h63]} && msg.num_b <= msg.num_a)
		else $error("capacity out of range");
	chk_names_open: assert property (
		s_ask(SIQR_Q_CFG_NAMES) |=> msg_valid && msg.kind == SIQR_M_NAME_OPEN
		&& msg.num_a <= 7'h63)
		else $error("name session not opened");
	chk_after_open: assert property (
		s_opened |=> is_rec || is_end)
		else $error("bad message after open");
	chk_rec_len: assert property (
		is_rec |-> msg.name_len inside {[5'h01:5'h10]})
		else $error("name length out of range");
	chk_rec_session: assert property (
		is_rec |-> open_q && cnt_q < tot_q)
		else $error("record outside session");
	chk_close_count: assert property (
		is_end |-> open_q && cnt_q == tot_q)
		else $error("close with wrong count");
endmodule : siqr_responder_assertions

bind siqr_responder siqr_responder_assertions siqr_responder_assertions_i (
	.aclk(aclk), .aresetn(aresetn), .qry(qry), .qry_valid(qry_valid),
	.qry_ready(qry_ready), .msg(msg), .msg_valid(msg_valid), .msg_ready(msg_ready));

// *** bench/siqr_peer.sv ***
module siqr_peer import siqr_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench commands
	input wire logic go,
	input wire siqr_qkind_t qkind,
	input wire logic stall,
	// Link to the responder
	output siqr_query_t qry = '0,
	output logic qry_valid = 1'b0,
	input wire logic qry_ready,
	input wire siqr_msg_t msg,
	input wire logic msg_valid,
	output logic msg_ready = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	int recs;
	int want;
	// Issues queries, takes messages and audits record counts
	always @(posedge aclk) begin
		if (!aresetn) begin
			qry_valid <= 1'b0;
			msg_ready <= 1'b0;
			recs <= 0;
		end else begin
			msg_ready <= !stall;
			// Released query lines stop showing the old cause
			if (qry_valid && qry_ready) begin
				qry_valid <= 1'b0;
				qry.cause <= ~qry.cause;
			end
			if (go && !qry_valid) begin
				qry_valid <= 1'b1;
				qry <= '{kind: qkind, cause: SIQR_CAUSE_RECORD_COUNT};
			end
			if (msg_valid && msg_ready) begin
				if (msg.kind == SIQR_M_NAME_OPEN) want <= int'(msg.num_a);
				if (msg.kind == SIQR_M_NAME_OPEN) recs <= 0;
				if (msg.kind == SIQR_M_NAME_REC) recs <= recs + 1;
				if (msg.kind == SIQR_M_NAME_CLOSE && recs != want) begin
					qry_valid <= 1'b1;
					qry <= '{kind: SIQR_Q_PEER_ERR, cause: SIQR_CAUSE_RECORD_COUNT};
				end
			end
		end
	end
endmodule : siqr_peer

// *** bench/tb_top.sv ***
module tb_top import siqr_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DEPTH = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rd;
	logic [31:0] lf = 32'h0000_0024;
	logic [3:0] ws = 4'hF;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, go = 1'b0, stall = 1'b0;
	logic awr, wr, bv, arr, rv, qv, qr, mv, mr, irq;
	logic [1:0] bresp, rresp;
	siqr_qkind_t kind = SIQR_Q_CFG_CAP;
	siqr_query_t qry;
	siqr_msg_t msg;
	siqr_msg_t got_q[$];
	siqr_msg_t exp_q[$];
	int miscompares = 0, n_compared = 0, cyc = 0;
	siqr_responder #(.NAME_DEPTH(DEPTH)) siqr_responder_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .qry(qry), .qry_valid(qv), .qry_ready(qr), .msg(msg),
		.msg_valid(mv), .msg_ready(mr), .irq(irq));
	siqr_peer siqr_peer_i (.aclk(aclk), .aresetn(aresetn), .go(go), .qkind(kind),
		.stall(stall), .qry(qry), .qry_valid(qv), .qry_ready(qr), .msg(msg),
		.msg_valid(mv), .msg_ready(mr));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic conclude();
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [132:0] e, input logic [132:0] s);
		n_compared++;
		if (e !== s) begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", what, e, s);
		end
	endtask : chk
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		br <= 1'b0;
		chk($sformatf("bresp %h", a), e, bresp);
	endtask : wrc
	task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rr <= 1'b0;
		chk($sformatf("rdata %h", a), d, rd);
		chk($sformatf("rresp %h", a), e, rresp);
	endtask : rdc
	// Sends one query and compares every message taken against the model
	task automatic ask(input siqr_qkind_t k);
		@(posedge aclk);
		kind <= k;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		do @(posedge aclk); while (qv || !qr);
		chk("msg count", exp_q.size(), got_q.size());
		foreach (exp_q[i]) begin
			chk("msg kind", exp_q[i].kind, got_q[i].kind);
			if (exp_q[i].kind != SIQR_M_NAME_CLOSE)
				chk("msg num_a", exp_q[i].num_a, got_q[i].num_a);
			if (exp_q[i].kind inside {SIQR_M_CFG_REPORT, SIQR_M_FIG_REPORT})
				chk("msg num_b", exp_q[i].num_b, got_q[i].num_b);
			if (exp_q[i].kind == SIQR_M_NAME_REC)
				chk("msg name", {exp_q[i].name_len, exp_q[i].name}, {got_q[i].name_len, got_q[i].name});
		end
		exp_q.delete();
		got_q.delete();
	endtask : ask
	// Clock, random source, far-side stalls, message capture and timeout
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		lf <= lfsr(lf);
		stall <= lf[2] & lf[5];
		cyc <= cyc + 1;
		if (mv && mr) got_q.push_back(msg);
		if (cyc == 30000) begin
			miscompares++;
			conclude();
		end
	end
	// Main sequence
	initial begin
		int mx;
		int us;
		int cnt;
		int st;
		logic [7:0] ofs;
		logic [127:0] nm [DEPTH];
		int ln [DEPTH];
		int sv [3];
		sv = '{6, 0, 2};
		st = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(SIQR_CTRL_OFS, SIQR_CTRL_RST, SIQR_RESP_OKAY);
		rdc(SIQR_CFG_CNT_OFS, SIQR_CNT_RST, SIQR_RESP_OKAY);
		rdc(8'h40, 32'h0000_0000, SIQR_RESP_SLVERR);
		wrc(8'h44, 32'hFFFF_FFFF, SIQR_RESP_SLVERR);
		wrc(SIQR_IRQ_EN_OFS, 32'h0000_000F, SIQR_RESP_OKAY);
		// Capacity reports: limits first, then random counts
		for (int n = 0; n < 8; n++) begin
			mx = (n < 2) ? 0 : (n < 4) ? 127 : int'(lf[6:0]);
			us = int'(lf[14:8]);
			ofs = n[0] ? SIQR_FIG_CNT_OFS : SIQR_CFG_CNT_OFS;
			wrc(ofs, {17'h00000, us[6:0], 1'b0, mx[6:0]}, SIQR_RESP_OKAY);
			mx = (mx < 1) ? 1 : (mx > 99) ? 99 : mx;
			us = (us > mx) ? mx : us;
			rdc(ofs, {17'h00000, 7'(us), 1'b0, 7'(mx)}, SIQR_RESP_OKAY);
			exp_q.push_back(siqr_msg_t'{n[0] ? SIQR_M_FIG_REPORT : SIQR_M_CFG_REPORT,
				7'(mx), 7'(us), 5'h00, 128'h0});
			ask(n[0] ? SIQR_Q_FIG_CAP : SIQR_Q_CFG_CAP);
			st = st | (1 << n[0]);
			chk("irq", 1'b1, irq);
		end
		// Status is read-only, mask and clear the interrupt
		wrc(SIQR_IRQ_STAT_OFS, 32'h0000_0000, SIQR_RESP_OKAY);
		rdc(SIQR_IRQ_STAT_OFS, st, SIQR_RESP_OKAY);
		wrc(SIQR_IRQ_EN_OFS, 32'h0000_0000, SIQR_RESP_OKAY);
		rdc(SIQR_IRQ_EN_OFS, 32'h0000_0000, SIQR_RESP_OKAY);
		chk("irq masked", 1'b0, irq);
		wrc(SIQR_IRQ_EN_OFS, 32'h0000_000F, SIQR_RESP_OKAY);
		wrc(SIQR_IRQ_CLR_OFS, st, SIQR_RESP_OKAY);
		rdc(SIQR_IRQ_STAT_OFS, 32'h0000_0000, SIQR_RESP_OKAY);
		chk("irq cleared", 1'b0, irq);
		// Name table with lengths at both ends of the range
		for (int i = 0; i < DEPTH; i++) begin
			ln[i] = (i == 0) ? 16 : (i == 1) ? 1 : 1 + int'(lf[3:0]);
			wrc(SIQR_NAME_SEL_OFS, {11'h000, 5'(ln[i]), 9'h000, 7'(i)}, SIQR_RESP_OKAY);
			for (int k = 0; k < 4; k++) begin
				nm[i][32 * k +: 32] = lf;
				wrc(SIQR_NAME_W0_OFS + 8'(4 * k), nm[i][32 * k +: 32], SIQR_RESP_OKAY);
			end
		end
		// Name sessions: truncated to the table, empty and short
		foreach (sv[j]) begin
			wrc(SIQR_CFG_CNT_OFS, {17'h00000, 7'(sv[j]), 1'b0, 7'h09}, SIQR_RESP_OKAY);
			cnt = (sv[j] > DEPTH) ? DEPTH : sv[j];
			exp_q.push_back(siqr_msg_t'{SIQR_M_NAME_OPEN, 7'(cnt), 7'h00, 5'h00, 128'h0});
			for (int i = 0; i < cnt; i++)
				exp_q.push_back(siqr_msg_t'{SIQR_M_NAME_REC, 7'(i), 7'h00, 5'(ln[i]), nm[i]});
			exp_q.push_back(siqr_msg_t'{SIQR_M_NAME_CLOSE, 7'h00, 7'h00, 5'h00, 128'h0});
			ask(SIQR_Q_CFG_NAMES);
		end
		// Session state after two records: idle, total 2, index past the last
		rdc(SIQR_STATUS_OFS, 32'h0000_0202, SIQR_RESP_OKAY);
		// Byte lane write changes the maximum only, stored count kept
		ws <= 4'h1;
		wrc(SIQR_CFG_CNT_OFS, 32'h0000_7F05, SIQR_RESP_OKAY);
		ws <= 4'hF;
		rdc(SIQR_CFG_CNT_OFS, 32'h0000_0205, SIQR_RESP_OKAY);
		// Incoming wrong-count error from the far side
		ask(SIQR_Q_PEER_ERR);
		rdc(SIQR_IRQ_STAT_OFS, 32'h0000_000C, SIQR_RESP_OKAY);
		chk("irq", 1'b1, irq);
		conclude();
	end
endmodule : tb_top
